// *** core/dac_link_pkg.sv ***
package dac_link_pkg;
    localparam int WORD_BITS = 16;
    localparam int NUM_CH    = 8;
    localparam int CODE_W    = 10;
    localparam int OFS_W     = 6;
    localparam int CH_W      = 3;
    localparam int BITCNT_W  = 5;
    localparam int FIFO_DEPTH = 8;

    // Word layout
    localparam int CMD_BIT       = 15;
    localparam int CH_MSB        = 14;
    localparam int CH_LSB        = 12;
    localparam int CODE_MSB      = 9;
    localparam int CODE_LSB      = 0;
    localparam int CTL_REF_BIT   = 0;
    localparam int CTL_CLR16_BIT = 1;
    localparam int OFS_LSB       = 2;
    localparam int OFS_MSB       = 7;
    localparam int CTL_CLEAR_BIT = 8;

    // Values after reset or clear, and frame bit counts
    localparam logic [CODE_W-1:0] CODE_RESET = 10'h200;
    localparam logic [OFS_W-1:0]  OFS_RESET  = 6'h20;
    localparam logic [BITCNT_W-1:0] LAST_BIT = 5'h0f;
    localparam logic [BITCNT_W-1:0] ALL_BITS = 5'h10;

    // Timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int SCK_HALF_NS     = 100;
    localparam int LOAD_PULSE_NS   = 300;
    localparam int SCK_HALF_CYCLES =
        (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOAD_CYCLES =
        (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 4;
    localparam int LD_W  = 4;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE  = 2'b11
    } host_state_t;
endpackage

// *** core/dac_link_if.sv ***
`timescale 1ns/1ns
interface dac_link_if;
    logic frame_sync_n;
    logic serial_clock_in;
    logic serial_data_in;
    logic load_strobe_n;
    logic async_clear_n;
    logic power_down_n;

    modport host (
        output frame_sync_n,
        output serial_clock_in,
        output serial_data_in,
        output load_strobe_n,
        output async_clear_n,
        output power_down_n
    );
    modport device (
        input frame_sync_n,
        input serial_clock_in,
        input serial_data_in,
        input load_strobe_n,
        input async_clear_n,
        input power_down_n
    );
endinterface

// *** core/word_fifo.sv ***
`timescale 1ns/1ns
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != FULL_CNT);
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == LAST_IDX) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == LAST_IDX) ? '0 : rd_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (push && !pop) begin
            cnt_reg <= cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule

// *** core/dac_load_host.sv ***
`timescale 1ns/1ns
module dac_load_host
    import dac_link_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    dac_link_if.host                  link,
    input  wire logic [WORD_BITS-1:0] word_data,
    input  wire logic                 word_valid,
    output logic                      word_ready,
    input  wire logic                 auto_update,
    input  wire logic                 load_req,
    input  wire logic                 clear_req,
    input  wire logic                 power_down_req,
    output logic                      busy
);
    host_state_t          state_reg;
    logic [WORD_BITS-1:0] tx_reg;
    logic [BITCNT_W-1:0]  bit_cnt_reg;
    logic [DIV_W-1:0]     div_reg;
    logic                 fs_n_reg;
    logic                 sck_reg;
    logic [LD_W-1:0]      ld_cnt_reg;
    logic                 ld_n_reg;
    logic                 clr_n_reg;
    logic                 pd_n_reg;
    logic                 busy_reg;
    logic [WORD_BITS-1:0] fifo_data;
    logic                 fifo_valid;
    logic                 fifo_ready;
    logic                 tick;

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYCLES - 1);
    localparam logic [LD_W-1:0]  LD_LOAD  = LD_W'(LOAD_CYCLES);

    word_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (word_data),
        .in_valid  (word_valid),
        .in_ready  (word_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );

    // The shifter drains the queue only between frames
    assign fifo_ready = (state_reg == ST_IDLE);
    assign tick       = (div_reg == DIV_LAST);

    assign link.frame_sync_n    = fs_n_reg;
    assign link.serial_clock_in = sck_reg;
    assign link.serial_data_in  = tx_reg[WORD_BITS-1];
    assign link.load_strobe_n   = ld_n_reg;
    assign link.async_clear_n   = clr_n_reg;
    assign link.power_down_n    = pd_n_reg;
    assign busy                 = busy_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else if (state_reg == ST_IDLE || tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // Clock idles high; data changes on rising edges, device samples falling
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= ST_IDLE;
            tx_reg      <= '0;
            bit_cnt_reg <= '0;
            fs_n_reg    <= 1'b1;
            sck_reg     <= 1'b1;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (fifo_valid) begin
                        tx_reg      <= fifo_data;
                        bit_cnt_reg <= '0;
                        fs_n_reg    <= 1'b0;
                        state_reg   <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (tick) begin
                        if (sck_reg) begin
                            sck_reg     <= 1'b0;
                            bit_cnt_reg <= bit_cnt_reg + 1'b1;
                        end else if (bit_cnt_reg == ALL_BITS) begin
                            fs_n_reg  <= 1'b1;
                            state_reg <= ST_DONE;
                        end else begin
                            sck_reg <= 1'b1;
                            tx_reg  <= {tx_reg[WORD_BITS-2:0], 1'b0};
                        end
                    end
                end
                ST_DONE: begin
                    sck_reg <= 1'b1;
                    if (tick) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    fs_n_reg  <= 1'b1;
                    sck_reg   <= 1'b1;
                end
            endcase
        end
    end

    // Strobe held low for auto update, or pulsed on request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_cnt_reg <= '0;
            ld_n_reg   <= 1'b1;
        end else begin
            if (load_req) begin
                ld_cnt_reg <= LD_LOAD;
            end else if (ld_cnt_reg != '0) begin
                ld_cnt_reg <= ld_cnt_reg - 1'b1;
            end
            ld_n_reg <= !(auto_update || load_req ||
                          ld_cnt_reg > LD_W'(1));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_n_reg <= 1'b1;
            pd_n_reg  <= 1'b1;
            busy_reg  <= 1'b0;
        end else begin
            clr_n_reg <= !clear_req;
            pd_n_reg  <= !power_down_req;
            busy_reg  <= (state_reg != ST_IDLE) || fifo_valid;
        end
    end
endmodule

// *** core/dac_load_device.sv ***
`timescale 1ns/1ns
module dac_load_device
    import dac_link_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    dac_link_if.device                          link,
    output logic [NUM_CH-1:0][CODE_W-1:0]       dac_code,
    output logic [NUM_CH-1:0][OFS_W-1:0]        offset_code,
    output logic [NUM_CH-1:0]                   ext_ref_select,
    output logic [NUM_CH-1:0]                   clear_to_sixteenth,
    output logic                                cleared,
    output logic                                powered_down,
    output logic                                word_seen
);
    // Link domain
    logic [BITCNT_W-1:0]    bit_cnt_reg;
    logic [WORD_BITS-2:0]   shift_reg;
    logic [WORD_BITS-1:0]   word_reg;
    logic                   word_tgl_reg;

    // System domain
    logic                   tgl_s1_reg;
    logic                   tgl_s2_reg;
    logic                   tgl_s3_reg;
    logic                   ld_s1_reg;
    logic                   ld_s2_reg;
    logic                   pd_s1_reg;
    logic                   pd_s2_reg;
    logic                   pd_reg;
    logic                   cleared_reg;
    logic                   seen_reg;
    logic                   clear_all_n;
    logic                   clear_pin_n;
    logic                   clr_s1_reg;
    logic                   clr_s2_reg;
    logic                   word_evt;
    logic                   load_low;
    logic                   is_data;
    logic [CH_W-1:0]        word_ch;
    logic [CODE_W-1:0]      word_code;

    logic [NUM_CH-1:0][CODE_W-1:0] stage_reg;
    logic [NUM_CH-1:0][CODE_W-1:0] stage_next;
    logic [NUM_CH-1:0][CODE_W-1:0] dac_reg;
    logic [NUM_CH-1:0][OFS_W-1:0]  ofs_reg;
    logic [NUM_CH-1:0]             ref_reg;
    logic [NUM_CH-1:0]             clr16_reg;
    logic [NUM_CH-1:0]             hit;
    logic [NUM_CH-1:0]             dac_upd;

    // Frame sync rising ends the frame even with the link clock stopped
    always_ff @(negedge link.serial_clock_in or posedge link.frame_sync_n
                or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= '0;
            shift_reg   <= '0;
        end else if (link.frame_sync_n) begin
            bit_cnt_reg <= '0;
            shift_reg   <= '0;
        end else if (bit_cnt_reg != ALL_BITS) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            shift_reg   <= {shift_reg[WORD_BITS-3:0],
                            link.serial_data_in};
        end
    end

    // Word held until the next full frame, long after the crossing settles
    always_ff @(negedge link.serial_clock_in or negedge rst_n) begin
        if (!rst_n) begin
            word_reg     <= '0;
            word_tgl_reg <= 1'b0;
        end else if (!link.frame_sync_n && bit_cnt_reg == LAST_BIT) begin
            word_reg     <= {shift_reg, link.serial_data_in};
            word_tgl_reg <= !word_tgl_reg;
        end
    end

    // Toggle crosses into the system clock; the third flop finds its edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
            tgl_s3_reg <= 1'b0;
        end else begin
            tgl_s1_reg <= word_tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
        end
    end

    // Strobe and power-down are plain levels, two flops each
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_s1_reg <= 1'b1;
            ld_s2_reg <= 1'b1;
            pd_s1_reg <= 1'b1;
            pd_s2_reg <= 1'b1;
        end else begin
            ld_s1_reg <= link.load_strobe_n;
            ld_s2_reg <= ld_s1_reg;
            pd_s1_reg <= link.power_down_n;
            pd_s2_reg <= pd_s1_reg;
        end
    end

    assign word_evt    = tgl_s2_reg ^ tgl_s3_reg;
    assign load_low    = !ld_s2_reg;
    assign is_data     = word_reg[CMD_BIT];
    assign word_ch     = word_reg[CH_MSB:CH_LSB];
    assign word_code   = word_reg[CODE_MSB:CODE_LSB];
    // A glitch on either pin clears; the clear pin is deliberately unfiltered
    assign clear_pin_n = rst_n & link.async_clear_n;

    // Release passes two flops so no register leaves clear a cycle early
    always_ff @(posedge clk or negedge clear_pin_n) begin
        if (!clear_pin_n) begin
            clr_s1_reg <= 1'b0;
            clr_s2_reg <= 1'b0;
        end else begin
            clr_s1_reg <= 1'b1;
            clr_s2_reg <= clr_s1_reg;
        end
    end
    assign clear_all_n = clr_s2_reg;

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_ch
            assign hit[i] = word_evt && (word_ch == CH_W'(i));
            assign stage_next[i] = (hit[i] && is_data) ? word_code
                                                        : stage_reg[i];
            assign dac_upd[i] = load_low;

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage_reg[i] <= CODE_RESET;
                end else begin
                    stage_reg[i] <= stage_next[i];
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ref_reg[i]   <= 1'b0;
                    clr16_reg[i] <= 1'b0;
                end else if (hit[i] && !is_data) begin
                    ref_reg[i]   <= word_reg[CTL_REF_BIT];
                    clr16_reg[i] <= word_reg[CTL_CLR16_BIT];
                end
            end

            always_ff @(posedge clk or negedge clear_all_n) begin
                if (!clear_all_n) begin
                    ofs_reg[i] <= OFS_RESET;
                end else if (hit[i] && !is_data) begin
                    ofs_reg[i] <= word_reg[OFS_MSB:OFS_LSB];
                end
            end

            // Strobe low when the word lands gives the automatic update
            always_ff @(posedge clk or negedge clear_all_n) begin
                if (!clear_all_n) begin
                    dac_reg[i] <= CODE_RESET;
                end else if (hit[i] && !is_data &&
                             word_reg[CTL_CLEAR_BIT]) begin
                    dac_reg[i] <= CODE_RESET;
                end else if (dac_upd[i]) begin
                    dac_reg[i] <= stage_next[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge clear_all_n) begin
        if (!clear_all_n) begin
            cleared_reg <= 1'b1;
        end else if (load_low) begin
            cleared_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_reg   <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            pd_reg   <= !pd_s2_reg;
            seen_reg <= word_evt;
        end
    end

    assign dac_code           = dac_reg;
    assign offset_code        = ofs_reg;
    assign ext_ref_select     = ref_reg;
    assign clear_to_sixteenth = clr16_reg;
    assign cleared            = cleared_reg;
    assign powered_down       = pd_reg;
    assign word_seen          = seen_reg;
endmodule

// *** tb/dac_link_asserts.sv ***
`timescale 1ns/1ns
module dac_link_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic frame_sync_n,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic load_strobe_n,
    input wire logic async_clear_n,
    input wire logic power_down_n
);
    logic       sck_prev_reg;
    logic [4:0] fall_cnt_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sck_prev_reg <= 1'b1;
        else sck_prev_reg <= serial_clock_in;
    end

    // Falls are counted per frame so a short or long word shows up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) fall_cnt_reg <= 5'h00;
        else if (frame_sync_n) fall_cnt_reg <= 5'h00;
        else if (sck_prev_reg && !serial_clock_in)
            fall_cnt_reg <= fall_cnt_reg + 5'h01;
    end

    a_idle_clock_high: assert property (
        $past(frame_sync_n) && frame_sync_n |-> serial_clock_in)
        else $error("serial clock not high between frames");
    a_clock_in_frame: assert property (
        $changed(serial_clock_in) |->
            !frame_sync_n || !$past(frame_sync_n, 2))
        else $error("serial clock moved outside a frame");
    a_clock_toggles: assert property (
        $fell(serial_clock_in) && !frame_sync_n |=>
            $rose(serial_clock_in) || $rose(frame_sync_n))
        else $error("serial clock low phase too long");
    a_frame_opens_high: assert property (
        $fell(frame_sync_n) |-> serial_clock_in ##1 !serial_clock_in)
        else $error("frame did not open with a clock fall");
    a_data_steady: assert property (
        $fell(serial_clock_in) && !frame_sync_n |-> $stable(serial_data_in))
        else $error("data moved at sampling edge");
    a_data_on_rise: assert property (
        $changed(serial_data_in) && !frame_sync_n && !$past(frame_sync_n)
            |-> $rose(serial_clock_in))
        else $error("data changed off a rising clock edge");
    a_sixteen_falls: assert property (
        $rose(frame_sync_n) |-> fall_cnt_reg == 5'h10)
        else $error("frame closed without sixteen falls");
    a_fall_cap: assert property (
        !frame_sync_n |-> fall_cnt_reg <= 5'h10)
        else $error("more than sixteen falls in a frame");
    a_frame_gap: assert property (
        $rose(frame_sync_n) |-> frame_sync_n [*2])
        else $error("frames too close together");
    a_strobe_min_pulse: assert property (
        $fell(load_strobe_n) |-> !load_strobe_n [*2])
        else $error("load strobe pulse too short");
endmodule

// *** tb/serial_dac_load_interface_bench.sv ***
`timescale 1ns/1ns
module serial_dac_load_interface_bench;
    import dac_link_pkg::*;
    logic                          clk, rst_n, word_valid, word_ready;
    logic                          auto_update, load_req, clear_req;
    logic                          power_down_req, busy, cleared;
    logic                          powered_down, word_seen, word_seen_b;
    logic                          full_seen;
    logic [WORD_BITS-1:0]          word_data;
    logic [NUM_CH-1:0][CODE_W-1:0] dac_code, dac_code_b;
    logic [NUM_CH-1:0][OFS_W-1:0]  offset_code;
    logic [NUM_CH-1:0]             ext_ref_select, clear_to_sixteenth;
    logic [NUM_CH-1:0]             ref_m, c16_m;
    logic [CODE_W-1:0]             stage [NUM_CH];
    logic [CODE_W-1:0]             code_m [NUM_CH];
    logic [OFS_W-1:0]              ofs_m [NUM_CH];
    logic [CODE_W-1:0]             c, c2;
    int                            fail_count, compares, seen_a, seen_b, ch;

    dac_link_if link ();
    dac_link_if bad_link ();

    dac_load_host u_dac_load_host (.clk(clk), .rst_n(rst_n), .link(link),
        .word_data(word_data), .word_valid(word_valid),
        .word_ready(word_ready), .auto_update(auto_update),
        .load_req(load_req), .clear_req(clear_req),
        .power_down_req(power_down_req), .busy(busy));
    dac_load_device u_dac_load_device (.clk(clk), .rst_n(rst_n),
        .link(link), .dac_code(dac_code), .offset_code(offset_code),
        .ext_ref_select(ext_ref_select),
        .clear_to_sixteenth(clear_to_sixteenth), .cleared(cleared),
        .powered_down(powered_down), .word_seen(word_seen));
    // Second device faces a bench driver that can break the framing
    dac_load_device u_dac_load_device_b (.clk(clk), .rst_n(rst_n),
        .link(bad_link), .dac_code(dac_code_b), .offset_code(),
        .ext_ref_select(), .clear_to_sixteenth(), .cleared(),
        .powered_down(), .word_seen(word_seen_b));
    dac_link_asserts chk (.clk(clk), .rst_n(rst_n),
        .frame_sync_n(link.frame_sync_n),
        .serial_clock_in(link.serial_clock_in),
        .serial_data_in(link.serial_data_in),
        .load_strobe_n(link.load_strobe_n),
        .async_clear_n(link.async_clear_n),
        .power_down_n(link.power_down_n));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) if (word_seen_b === 1'b1) seen_b++;
    always @(posedge clk) if (word_seen === 1'b1) seen_a++;

    function automatic logic [15:0] data_word(int n, logic [CODE_W-1:0] v);
        return {1'b1, 3'(n), 2'b00, v};
    endfunction

    function automatic logic [15:0] ctl_word(int n, logic [OFS_W-1:0] o,
                                             logic c16, logic rf);
        return {1'b0, 3'(n), 4'h0, o, c16, rf};
    endfunction

    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task final_report;
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Leaves valid high so back-to-back pushes need no idle cycle between words
    task push(input logic [15:0] w);
        int n;
        word_data = w;
        word_valid = 1'b1;
        n = 0;
        while (word_ready !== 1'b1 && n < 2000) begin
            full_seen = 1'b1;
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            fail_count++;
            final_report;
        end
        @(negedge clk);
    endtask

    task drain;
        int n;
        word_valid = 1'b0;
        n = 0;
        repeat (3) @(negedge clk);
        while (busy !== 1'b0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        repeat (8) @(negedge clk);
        check({15'h0, busy}, 16'h0000);
    endtask

    task check_codes;
        for (int i = 0; i < NUM_CH; i++) begin
            check({6'h0, dac_code[i]}, {6'h0, code_m[i]});
            check({10'h0, offset_code[i]}, {10'h0, ofs_m[i]});
        end
    endtask

    // Link clock of 6 ns runs only inside the frame
    task bad_frame(input logic [15:0] w, input int nbits);
        #7 bad_link.frame_sync_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            bad_link.serial_data_in = w[15-i];
            #3 bad_link.serial_clock_in = 1'b0;
            #3 bad_link.serial_clock_in = 1'b1;
        end
        #3 bad_link.frame_sync_n = 1'b1;
        bad_link.serial_data_in = ~bad_link.serial_data_in;
        repeat (8) @(negedge clk);
    endtask

    initial begin
        #3_000_000;
        fail_count++;
        final_report;
    end

    initial begin
        rst_n = 1'b0;
        word_data = '0;
        word_valid = 1'b0;
        auto_update = 1'b0;
        load_req = 1'b0;
        clear_req = 1'b0;
        power_down_req = 1'b0;
        full_seen = 1'b0;
        fail_count = 0;
        compares = 0;
        seen_a = 0;
        seen_b = 0;
        bad_link.frame_sync_n = 1'b1;
        bad_link.serial_clock_in = 1'b1;
        bad_link.serial_data_in = 1'b0;
        bad_link.load_strobe_n = 1'b0;
        bad_link.async_clear_n = 1'b1;
        bad_link.power_down_n = 1'b1;
        for (int i = 0; i < NUM_CH; i++) begin
            code_m[i] = CODE_RESET;
            stage[i] = CODE_RESET;
            ofs_m[i] = OFS_RESET;
        end
        void'($urandom(32'h5690f24d));
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check_codes;
        check({ext_ref_select, clear_to_sixteenth}, 16'h0000);
        check({11'h0, cleared, powered_down, word_seen, busy, word_ready},
              16'h0011);
        check({10'h0, link.frame_sync_n, link.serial_clock_in,
               link.load_strobe_n, link.async_clear_n, link.power_down_n,
               link.serial_data_in}, 16'h003e);
        // Twelve words fill the buffer and stall the pushes; strobe stays high meanwhile
        for (int k = 0; k < 12; k++) begin
            ch = k % NUM_CH;
            c = (k == 0) ? 10'h000 : (k == 1) ? 10'h3ff : CODE_W'($urandom);
            stage[ch] = c;
            push(data_word(ch, c));
        end
        drain;
        check({15'h0, full_seen}, 16'h0001);
        check_codes;
        load_req = 1'b1;
        @(negedge clk);
        load_req = 1'b0;
        repeat (8) @(negedge clk);
        for (int i = 0; i < NUM_CH; i++) code_m[i] = stage[i];
        check_codes;
        auto_update = 1'b1;
        for (int k = 0; k < 8; k++) begin
            ch = int'($urandom % NUM_CH);
            c = CODE_W'($urandom);
            stage[ch] = c;
            code_m[ch] = c;
            push(data_word(ch, c));
        end
        drain;
        check_codes;
        auto_update = 1'b0;
        for (int k = 0; k < NUM_CH; k++) begin
            ofs_m[k] = OFS_W'($urandom);
            ref_m[k] = 1'($urandom);
            c16_m[k] = 1'($urandom);
            push(ctl_word(k, ofs_m[k], c16_m[k], ref_m[k]));
        end
        drain;
        check_codes;
        check({ext_ref_select, clear_to_sixteenth}, {ref_m, c16_m});
        // Channel clear resets one main code; staging is left alone
        ch = int'($urandom % NUM_CH);
        ofs_m[ch] = OFS_W'($urandom);
        code_m[ch] = CODE_RESET;
        push(ctl_word(ch, ofs_m[ch], c16_m[ch], ref_m[ch]) |
             (16'h0001 << CTL_CLEAR_BIT));
        drain;
        check_codes;
        check({ext_ref_select, clear_to_sixteenth}, {ref_m, c16_m});
        check(16'(seen_a), 16'h001d);
        clear_req = 1'b1;
        repeat (3) @(negedge clk);
        for (int i = 0; i < NUM_CH; i++) begin
            code_m[i] = CODE_RESET;
            ofs_m[i] = OFS_RESET;
        end
        check_codes;
        check({15'h0, cleared}, 16'h0001);
        clear_req = 1'b0;
        repeat (4) @(negedge clk);
        check_codes;
        power_down_req = 1'b1;
        repeat (6) @(negedge clk);
        check({14'h0, powered_down, link.power_down_n}, 16'h0002);
        power_down_req = 1'b0;
        repeat (6) @(negedge clk);
        check({14'h0, powered_down, link.power_down_n}, 16'h0001);
        c = CODE_W'($urandom) | 10'h001;
        c2 = CODE_W'($urandom);
        bad_frame(data_word(1, c), 10);
        bad_frame(data_word(2, c2), 16);
        check({6'h0, dac_code_b[1]}, {6'h0, CODE_RESET});
        check({6'h0, dac_code_b[2]}, {6'h0, c2});
        check(16'(seen_b), 16'h0001);
        final_report;
    end
endmodule
